// file: rtl/wwd_top.sv
// Windowed watchdog timer with APB register slave
`timescale 1ns/1ps
`default_nettype none
module wwd_top
	import wwd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_power_oscillator,
	input wire logic deep_sleep,
	output logic warn_irq,
	output logic chip_reset
);
	wwd_cfg_s cfg_ff;
	wwd_cfg_s nxt_cfg;
	wwd_cfg_s cfg_req_ff;
	wwd_cfg_s nxt_cfg_req;
	wwd_stat_s stat_ff;
	wwd_stat_s nxt_stat;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic [CNT_W-1:0] timeout_ff;
	logic [CNT_W-1:0] warn_ff;
	logic [CNT_W-1:0] window_ff;
	logic [1:0] presc_ff;
	logic armed_ff;
	logic warn_hit_ff;
	logic chip_reset_ff;
	logic warn_irq_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic [31:0] rd_data;
	logic rd_hit;
	logic wr_en;
	logic setup;
	logic osc_rise;
	logic step;
	logic running;
	logic feed_ok;
	logic feed_bad;
	logic expire;
	logic wd_event;
	logic fire_reset;
	logic warn_now;
	logic to_wr_ok;
	logic [CNT_W-1:0] wdata24;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign wdata24 = pwdata[CNT_W-1:0];

	// Oscillator edges are the only time base of the counter
	wwd_tick_sync u_tick_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in(low_power_oscillator),
		.rise(osc_rise)
	);

	// Counter runs when enabled, and in deep sleep only if allowed
	assign running = cfg_ff.enable & (~deep_sleep | cfg_ff.sleep_run);
	assign step = running & osc_rise & (presc_ff == PRESCALE_LAST);
	assign expire = step & (count_ff == '0);
	assign warn_now = step & (count_ff == warn_ff);

	// Feed sequence checking
	always_comb begin
		feed_ok = 1'b0;
		feed_bad = 1'b0;
		if (wr_en) begin
			if (paddr == OFS_FEED) begin
				if (pwdata[7:0] == FEED_SECOND && armed_ff) begin
					if (count_ff > window_ff) begin
						feed_bad = 1'b1;
					end else begin
						feed_ok = 1'b1;
					end
				end else if (pwdata[7:0] != FEED_FIRST) begin
					feed_bad = 1'b1;
				end
			end else if (armed_ff) begin
				feed_bad = 1'b1;
			end
		end
	end

	// Feed faults only count once the watchdog is enabled
	assign wd_event = expire | (feed_bad & cfg_ff.enable);
	assign fire_reset = wd_event & cfg_ff.reset_en;

	// Time-out value is locked by protection until the warning point
	assign to_wr_ok = ~cfg_ff.protect | warn_hit_ff;

	// First key write arms the feed check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_ff <= 1'b0;
		end else if (wr_en) begin
			armed_ff <= (paddr == OFS_FEED) && (pwdata[7:0] == FEED_FIRST);
		end
	end

	// Prescaler divides oscillator edges by four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_ff <= 2'h0;
		end else if (fire_reset || feed_ok) begin
			presc_ff <= 2'h0;
		end else if (running && osc_rise) begin
			presc_ff <= presc_ff + 2'h1;
		end
	end

	// Down counter
	always_comb begin
		nxt_count = count_ff;
		if (fire_reset || feed_ok) begin
			nxt_count = timeout_ff;
		end else if (expire) begin
			nxt_count = timeout_ff;
		end else if (step) begin
			nxt_count = count_ff - 24'h000001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= TIMEOUT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Warning point reached since the last valid feed or watchdog reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_hit_ff <= 1'b0;
		end else if (fire_reset || feed_ok) begin
			warn_hit_ff <= 1'b0;
		end else if (warn_now) begin
			warn_hit_ff <= 1'b1;
		end
	end

	// Time-out, warning and window values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_ff <= TIMEOUT_RST;
		end else if (wr_en && paddr == OFS_TIMEOUT && to_wr_ok) begin
			if (wdata24 < TIMEOUT_MIN) begin
				timeout_ff <= TIMEOUT_MIN;
			end else begin
				timeout_ff <= wdata24;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_ff <= WARN_RST;
		end else if (wr_en && paddr == OFS_WARN) begin
			warn_ff <= wdata24;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_ff <= WINDOW_RST;
		end else if (wr_en && paddr == OFS_WINDOW) begin
			window_ff <= wdata24;
		end
	end

	// Requested mode, enable is sticky
	always_comb begin
		nxt_cfg_req = cfg_req_ff;
		if (fire_reset) begin
			nxt_cfg_req = CFG_RST;
		end else if (wr_en && paddr == OFS_MODE) begin
			nxt_cfg_req.enable = cfg_req_ff.enable | pwdata[MODE_ENABLE];
			nxt_cfg_req.reset_en = pwdata[MODE_RESET_EN];
			nxt_cfg_req.protect = pwdata[MODE_PROTECT];
			nxt_cfg_req.sleep_run = pwdata[MODE_SLEEP_RUN];
		end
	end

	// Active mode follows the request only at a valid feed
	always_comb begin
		nxt_cfg = cfg_ff;
		if (fire_reset) begin
			nxt_cfg = CFG_RST;
		end else if (feed_ok) begin
			nxt_cfg = cfg_req_ff;
			nxt_cfg.enable = cfg_ff.enable | cfg_req_ff.enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_req_ff <= CFG_RST;
			cfg_ff <= CFG_RST;
		end else begin
			cfg_req_ff <= nxt_cfg_req;
			cfg_ff <= nxt_cfg;
		end
	end

	// Sticky status, hardware set wins over write one to clear
	always_comb begin
		nxt_stat = stat_ff;
		if (wr_en && paddr == OFS_STATUS) begin
			nxt_stat.timeout = stat_ff.timeout & ~pwdata[STAT_TIMEOUT];
			nxt_stat.warn = stat_ff.warn & ~pwdata[STAT_WARN];
			nxt_stat.wd_reset = stat_ff.wd_reset & ~pwdata[STAT_WD_RESET];
		end
		if (wd_event && !cfg_ff.reset_en) begin
			nxt_stat.timeout = 1'b1;
		end
		if (warn_now) begin
			nxt_stat.warn = 1'b1;
		end
		if (fire_reset) begin
			nxt_stat.wd_reset = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff <= STAT_RST;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_reset_ff <= 1'b0;
		end else begin
			chip_reset_ff <= fire_reset;
		end
	end

	// Interrupt line follows the warning and time-out flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_irq_ff <= 1'b0;
		end else begin
			warn_irq_ff <= nxt_stat.warn | nxt_stat.timeout;
		end
	end

	assign chip_reset = chip_reset_ff;
	assign warn_irq = warn_irq_ff;

	// Read decode
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		if (paddr == OFS_MODE) begin
			rd_data[MODE_ENABLE] = cfg_req_ff.enable;
			rd_data[MODE_RESET_EN] = cfg_req_ff.reset_en;
			rd_data[MODE_PROTECT] = cfg_req_ff.protect;
			rd_data[MODE_SLEEP_RUN] = cfg_req_ff.sleep_run;
		end else if (paddr == OFS_TIMEOUT) begin
			rd_data[CNT_W-1:0] = timeout_ff;
		end else if (paddr == OFS_FEED) begin
			rd_data = 32'h0000_0000;
		end else if (paddr == OFS_COUNT) begin
			rd_data[CNT_W-1:0] = count_ff;
		end else if (paddr == OFS_WARN) begin
			rd_data[CNT_W-1:0] = warn_ff;
		end else if (paddr == OFS_WINDOW) begin
			rd_data[CNT_W-1:0] = window_ff;
		end else if (paddr == OFS_STATUS) begin
			rd_data[STAT_TIMEOUT] = stat_ff.timeout;
			rd_data[STAT_WARN] = stat_ff.warn;
			rd_data[STAT_WD_RESET] = stat_ff.wd_reset;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Answer captured in the setup cycle, zero wait access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
			pslverr_ff <= ~rd_hit;
		end
	end

	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;
	assign pready = 1'b1;

endmodule : wwd_top
`default_nettype wire

// file: rtl/wwd_pkg.sv
// Package with register map, field layout and reset values of the windowed watchdog
package wwd_pkg;

	localparam int ADDR_W = 8;
	localparam int CNT_W = 24;

	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FEED = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_WARN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

	localparam int MODE_ENABLE = 0;
	localparam int MODE_RESET_EN = 1;
	localparam int MODE_PROTECT = 2;
	localparam int MODE_SLEEP_RUN = 3;
	localparam int STAT_TIMEOUT = 0;
	localparam int STAT_WARN = 1;
	localparam int STAT_WD_RESET = 2;

	localparam logic [7:0] FEED_FIRST = 8'haa;
	localparam logic [7:0] FEED_SECOND = 8'h55;

	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam logic [CNT_W-1:0] TIMEOUT_MIN = 24'h0000ff;
	localparam logic [CNT_W-1:0] TIMEOUT_RST = 24'hffffff;
	localparam logic [CNT_W-1:0] WARN_RST = 24'h000000;
	localparam logic [CNT_W-1:0] WINDOW_RST = 24'hffffff;

	typedef struct packed {
		logic sleep_run;
		logic protect;
		logic reset_en;
		logic enable;
	} wwd_cfg_s;

	localparam wwd_cfg_s CFG_RST = 4'h0;

	typedef struct packed {
		logic wd_reset;
		logic warn;
		logic timeout;
	} wwd_stat_s;

	localparam wwd_stat_s STAT_RST = 3'h0;

endpackage : wwd_pkg

// file: rtl/wwd_tick_sync.sv
// Three stage synchroniser and rising edge detector for the watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic rise
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic nxt_level;

	// Level moves only when second and third stages agree
	always_comb begin
		nxt_level = level_ff;
		if (s2_ff == s3_ff) begin
			nxt_level = s3_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	assign rise = nxt_level & ~level_ff;

endmodule : wwd_tick_sync
`default_nettype wire

// file: test/wwd_checker.sv
// Port assertions for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module wwd_checker
	import wwd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic chip_reset,
	input wire logic warn_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_en;
	logic wdr_ff;
	assign rd_en = psel && !penable && !pwrite;
	// Expected watchdog reset flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdr_ff <= 1'b0;
		end else if (chip_reset) begin
			wdr_ff <= 1'b1;
		end else if (psel && penable && pwrite && paddr == OFS_STATUS && pwdata[STAT_WD_RESET]) begin
			wdr_ff <= 1'b0;
		end
	end
	unmapped_err_a: assert property (psel && !penable && paddr > OFS_STATUS |=> pslverr)
		else $error("unmapped access without error");
	mapped_ok_a: assert property (psel && !penable && paddr <= OFS_STATUS
		&& paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped access flagged");
	timeout_range_a: assert property (rd_en && paddr == OFS_TIMEOUT
		|=> prdata[31:24] == 8'h00 && prdata[23:0] >= TIMEOUT_MIN) else $error("timeout out of range");
	count_width_a: assert property (rd_en && paddr == OFS_COUNT |=> prdata[31:24] == 8'h00)
		else $error("count wider than 24 bits");
	pulse_width_a: assert property ($rose(chip_reset) |=> !chip_reset)
		else $error("reset pulse too long");
	wd_flag_a: assert property (rd_en && paddr == OFS_STATUS && !chip_reset
		|=> prdata[STAT_WD_RESET] == wdr_ff) else $error("watchdog reset flag wrong");
	feed_read_a: assert property (rd_en && paddr == OFS_FEED |=> prdata == 32'h0)
		else $error("feed reads nonzero");
	mode_read_a: assert property (rd_en && paddr == OFS_MODE |=> prdata[31:4] == 28'h0)
		else $error("mode upper bits set");
	cover property (chip_reset);
	cover property ($rose(warn_irq));
	cover property (pslverr);
endmodule : wwd_checker
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import wwd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, osc, deep_sleep, err;
	logic pready, pslverr, warn_irq, chip_reset;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv, r0;
	logic [1:0] div;
	int fail_count, n_tests, n_rst, k;
	wwd_top i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .low_power_oscillator(osc), .deep_sleep(deep_sleep),
		.warn_irq(warn_irq), .chip_reset(chip_reset));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Oscillator toggles every four bus clocks
	always @(posedge pclk) begin
		div <= div + 2'h1;
		if (div == 2'h3) osc <= ~osc;
	end
	always @(posedge pclk) begin
		if (chip_reset === 1'b1) n_rst <= n_rst + 1;
	end
	task automatic results();
		$display("Checks %0d, errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), rv, exp);
	endtask : rd
	task automatic feed();
		wr(OFS_FEED, {24'h0, FEED_FIRST});
		wr(OFS_FEED, {24'h0, FEED_SECOND});
	endtask : feed
	task automatic wait_irq();
		repeat (3) @(posedge pclk);
		k = 0;
		while (warn_irq !== 1'b1 && k < 9000) begin
			@(posedge pclk);
			k++;
		end
		check("irq raised", {31'h0, warn_irq}, 32'h1);
	endtask : wait_irq
	initial begin
		{presetn, psel, penable, pwrite, osc, deep_sleep} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		div = 2'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_MODE, 32'h0);
		rd(OFS_TIMEOUT, 32'hffffff);
		rd(OFS_WINDOW, 32'hffffff);
		rd(OFS_STATUS, 32'h0);
		rd(OFS_FEED, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		wr(OFS_TIMEOUT, 32'h0);
		rd(OFS_TIMEOUT, 32'hff);
		wr(OFS_WARN, 32'h80);
		wr(OFS_MODE, 32'h5);
		feed();
		wr(OFS_TIMEOUT, 32'h120);
		rd(OFS_TIMEOUT, 32'hff);
		wr(OFS_MODE, 32'h0);
		rd(OFS_MODE, 32'h1);
		wait_irq();
		rd(OFS_STATUS, 32'h2);
		wr(OFS_TIMEOUT, 32'h120);
		rd(OFS_TIMEOUT, 32'h120);
		wr(OFS_STATUS, 32'h7);
		wait_irq();
		rd(OFS_STATUS, 32'h1);
		check("reset pulses", n_rst, 0);
		deep_sleep <= 1'b1;
		apb(1'b0, OFS_COUNT, 32'h0);
		r0 = rv;
		repeat (100) @(posedge pclk);
		rd(OFS_COUNT, r0);
		deep_sleep <= 1'b0;
		repeat (100) @(posedge pclk);
		apb(1'b0, OFS_COUNT, 32'h0);
		check("count resumes", {31'h0, rv < r0}, 32'h1);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_WINDOW, 32'h10);
		feed();
		rd(OFS_STATUS, 32'h1);
		wr(OFS_WINDOW, 32'hffffff);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_MODE, 32'h3);
		feed();
		wr(OFS_FEED, 32'h12);
		repeat (3) @(posedge pclk);
		check("reset pulses", n_rst, 1);
		rd(OFS_STATUS, 32'h4);
		rd(OFS_MODE, 32'h0);
		// Mid-run reset clears the flag and restores the reset time-out value
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS, 32'h0);
		rd(OFS_TIMEOUT, 32'hffffff);
		wr(OFS_TIMEOUT, 32'hff);
		wr(OFS_MODE, 32'hb);
		feed();
		deep_sleep <= 1'b1;
		k = 0;
		while (n_rst < 2 && k < 9000) begin
			@(posedge pclk);
			k++;
		end
		check("expiry cycles", {31'h0, k inside {[8100:8300]}}, 32'h1);
		results();
	end
	initial begin
		#4000000;
		fail_count++;
		results();
	end
endmodule : tb_top
bind wwd_top wwd_checker i_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .chip_reset(chip_reset), .warn_irq(warn_irq));
`default_nettype wire
